//--- pkg/lch_params.svh
`ifndef LCH_PARAMS_SVH
`define LCH_PARAMS_SVH

// bank sizes: island inputs, virtual bits, host bits and output channels
`define LCH_NUM_BITS 4
`define LCH_NUM_CH 4
`define LCH_IDX_W 2

// reset values of the block's state
`define LCH_OUT_RST 1'b0
`define LCH_DATA_RST 1'b0
`define LCH_TRIG_RST 1'b0
`define LCH_SYNC_RST 1'b0
`define LCH_PULSE_RST 1'b0
`define LCH_EN_RST 1'b0
`define LCH_LATCHED_RST 1'b0
`define LCH_BANK_RST 4'h0

`endif

//--- pkg/lch_pkg.sv
package lch_pkg;

`include "lch_params.svh"

  // where a block input takes its value from
  typedef enum logic [2:0] {
    LCH_SRC_CONST0,
    LCH_SRC_CONST1,
    LCH_SRC_ISLAND,
    LCH_SRC_VIRTUAL,
    LCH_SRC_HOST,
    LCH_SRC_CHAIN
  } lch_src_e;

  // enable: constant on, constant off, or a boolean source
  typedef enum logic [1:0] {
    LCH_EN_ALWAYS_ON,
    LCH_EN_ALWAYS_OFF,
    LCH_EN_SIGNAL
  } lch_en_mode_e;

  // which trigger level latches the output
  typedef enum logic {
    LCH_POL_LOW,
    LCH_POL_HIGH
  } lch_pol_e;

  // evaluation state of the latch
  typedef enum logic [1:0] {
    LCH_ST_FOLLOW,
    LCH_ST_HOLD,
    LCH_ST_FROZEN
  } lch_st_e;

  typedef logic [`LCH_IDX_W-1:0] lch_idx_t;
  typedef logic [`LCH_NUM_BITS-1:0] lch_bank_t;

  typedef struct packed {
    lch_src_e kind;
    lch_idx_t idx;
  } lch_src_sel_s;

  typedef struct packed {
    logic mapped;
    lch_idx_t ch;
  } lch_dest_s;

  typedef struct packed {
    lch_pol_e pol;
    logic invert;
    lch_en_mode_e en_mode;
    lch_src_sel_s en_src;
    lch_src_sel_s trig_src;
    lch_src_sel_s op_src;
    lch_dest_s dest;
  } lch_cfg_s;

  typedef struct packed {
    lch_bank_t island;
    lch_bank_t virt;
    lch_bank_t host;
    logic chain;
  } lch_srcs_s;

endpackage : lch_pkg

//--- hw/lch_sync.sv
`timescale 1ns/1ps
`include "lch_params.svh"

module lch_sync import lch_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw pin bits and their synchronised copies
  input wire lch_bank_t async_in,
  output lch_bank_t sync_out
);

  genvar b;

  // two flops per bit; the first is read by the second only
  for (b = 0; b < `LCH_NUM_BITS; b++) begin : g_bit
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
      meta_d = async_in[b];
      sync_d = meta_q;
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        meta_q <= `LCH_SYNC_RST;
        sync_q <= `LCH_SYNC_RST;
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end

    assign sync_out[b] = sync_q;
  end

endmodule : lch_sync

//--- hw/lch_src_mux.sv
`timescale 1ns/1ps
`include "lch_params.svh"

module lch_src_mux import lch_pkg::*; (
  // source selection
  input wire lch_src_sel_s sel,
  // all candidate sources
  input wire lch_srcs_s srcs,
  // selected bit
  output logic src_bit
);

  // pick one bit; unknown kinds read as zero
  always_comb begin
    src_bit = 1'b0;
    case (sel.kind)
      LCH_SRC_CONST0: src_bit = 1'b0;
      LCH_SRC_CONST1: src_bit = 1'b1;
      LCH_SRC_ISLAND: src_bit = srcs.island[sel.idx];
      LCH_SRC_VIRTUAL: src_bit = srcs.virt[sel.idx];
      LCH_SRC_HOST: src_bit = srcs.host[sel.idx];
      LCH_SRC_CHAIN: src_bit = srcs.chain;
      default: src_bit = 1'b0;
    endcase
  end

endmodule : lch_src_mux

//--- hw/lch_latch_top.sv
`timescale 1ns/1ps
`include "lch_params.svh"

// Contract
// - low-level: trigger 0 holds output, trigger 1 makes it transparent
// - low-level standard: output follows input while high, holds it at fall
// - low-level inverted: output is input complement, holds complement at fall
// - high-level: trigger 1 holds output, trigger 0 makes it transparent
// - high-level standard: output follows input while low, holds it at rise
// - high-level inverted: output is input complement, holds complement at rise
// - one boolean output, delivered straight or inverted by configuration
// - enable from a boolean source or always-on / always-off constants
// - disabled block does nothing; output frozen at its last value
// - inputs keep being sampled while disabled; re-enable uses latest values
// - output follows input in the same cycle transparency returns
// - mapped channel is driven only by the block; host bits stay usable
// - first stage of a chain feeds the second stage, channel set to none
// - trigger source may be the first stage output of a chain
module lch_latch_top import lch_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // static configuration
  input wire lch_cfg_s cfg,
  // island input pins, asynchronous
  input wire lch_bank_t island_in,
  // virtual module bits, same clock
  input wire lch_bank_t virt_bits,
  // host written bits, same clock, also the channel data
  input wire lch_bank_t host_bits,
  // output of a first stage block, same clock
  input wire logic chain_in,
  // digital output channels
  output lch_bank_t do_ch,
  // feed to a second stage block
  output logic chain_out,
  // status
  output logic latch_out,
  output logic enabled,
  output logic latched,
  output logic capture_pulse,
  output lch_bank_t dedicated,
  output lch_bank_t host_readback
);

  // synchronised island pins
  lch_bank_t island_s;

  // gathered sources and selected bits
  lch_srcs_s srcs;
  logic en_src_bit;
  logic trig_now;
  logic op_now;

  // derived per-cycle terms
  logic enable_now;
  logic transp_now;
  logic transp_prev;
  logic latch_edge;

  // latch state
  lch_st_e st_q;
  lch_st_e st_d;
  logic data_q;
  logic data_d;
  logic trig_prev_q;
  logic trig_prev_d;
  logic out_q;
  logic out_d;
  logic cap_q;
  logic cap_d;
  logic en_q;
  logic en_d;
  logic latched_q;
  logic latched_d;

  // output side state
  lch_bank_t do_q;
  lch_bank_t do_d;
  lch_bank_t ded_q;
  lch_bank_t ded_d;
  lch_bank_t rb_q;
  lch_bank_t rb_d;
  logic chain_q;
  logic chain_d;

  // pins cross into the clock domain before anything reads them
  lch_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(island_in),
    .sync_out(island_s)
  );

  // one pool of sources shared by the three input selectors
  always_comb begin
    srcs.island = island_s;
    srcs.virt = virt_bits;
    srcs.host = host_bits;
    srcs.chain = chain_in;
  end

  // enable selector
  lch_src_mux u_en_mux (
    .sel(cfg.en_src),
    .srcs(srcs),
    .src_bit(en_src_bit)
  );

  // trigger selector; chain kind takes a first stage output
  lch_src_mux u_trig_mux (
    .sel(cfg.trig_src),
    .srcs(srcs),
    .src_bit(trig_now)
  );

  // operational input selector
  lch_src_mux u_op_mux (
    .sel(cfg.op_src),
    .srcs(srcs),
    .src_bit(op_now)
  );

  // enable: constants override the boolean source
  always_comb begin
    enable_now = 1'b0;
    case (cfg.en_mode)
      LCH_EN_ALWAYS_ON: enable_now = 1'b1;
      LCH_EN_ALWAYS_OFF: enable_now = 1'b0;
      LCH_EN_SIGNAL: enable_now = en_src_bit;
      default: enable_now = 1'b0;
    endcase
  end

  // transparency depends on the polarity bit
  always_comb begin
    if (cfg.pol == LCH_POL_LOW) begin
      transp_now = trig_now;
      transp_prev = trig_prev_q;
    end else begin
      transp_now = ~trig_now;
      transp_prev = ~trig_prev_q;
    end
  end

  // leaving transparency is the capture moment; using the previous level
  // rather than the raw level keeps a held trigger from capturing twice
  always_comb begin
    latch_edge = transp_prev & ~transp_now;
  end

  // next state of the latch core
  always_comb begin
    st_d = st_q;
    data_d = data_q;
    if (!enable_now) begin
      st_d = LCH_ST_FROZEN;
    end else if (transp_now) begin
      st_d = LCH_ST_FOLLOW;
      data_d = op_now;
    end else begin
      st_d = LCH_ST_HOLD;
      if (latch_edge) begin
        // capture the input seen at the edge itself, not a cycle later
        data_d = op_now;
      end
    end
  end

  // output value for the state just chosen; built from st_d, not st_q,
  // so a follow or a capture shows at the very edge that decides it
  always_comb begin
    out_d = out_q;
    case (st_d)
      LCH_ST_FOLLOW: out_d = op_now ^ cfg.invert;
      LCH_ST_HOLD: out_d = data_d ^ cfg.invert;
      LCH_ST_FROZEN: out_d = out_q;
      default: out_d = out_q;
    endcase
  end

  // latch core registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= LCH_ST_FROZEN;
      data_q <= `LCH_DATA_RST;
      out_q <= `LCH_OUT_RST;
    end else begin
      st_q <= st_d;
      data_q <= data_d;
      out_q <= out_d;
    end
  end

  // trigger history keeps running while disabled, so an edge seen only
  // while off is gone for good once the block comes back
  always_comb begin
    trig_prev_d = trig_now;
  end

  // trigger history register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      trig_prev_q <= `LCH_TRIG_RST;
    end else begin
      trig_prev_q <= trig_prev_d;
    end
  end

  // status flags follow the state just chosen, so they line up with latch_out
  always_comb begin
    en_d = enable_now;
    latched_d = (st_d == LCH_ST_HOLD);
  end

  // status registers; the latched flag has a flop of its own, not a decode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_q <= `LCH_EN_RST;
      latched_q <= `LCH_LATCHED_RST;
    end else begin
      en_q <= en_d;
      latched_q <= latched_d;
    end
  end

  // capture strobe: one cycle, only when an enabled block really latches
  always_comb begin
    cap_d = enable_now & latch_edge;
  end

  // capture strobe register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cap_q <= `LCH_PULSE_RST;
    end else begin
      cap_q <= cap_d;
    end
  end

  // channel routing: the mapped channel is taken from the host for good;
  // the other channels still pass host data, one cycle late like the output
  for (genvar c = 0; c < `LCH_NUM_CH; c++) begin : g_ch
    logic hit;

    always_comb begin
      hit = cfg.dest.mapped && (cfg.dest.ch == lch_idx_t'(c));
      ded_d[c] = hit;
      do_d[c] = hit ? out_d : host_bits[c];
    end
  end

  // the host still sees what it wrote, even for a dedicated channel
  always_comb begin
    rb_d = host_bits;
  end

  // readback register; one cycle behind the host write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rb_q <= `LCH_BANK_RST;
    end else begin
      rb_q <= rb_d;
    end
  end

  // unmapped destination means the value only feeds the next stage
  always_comb begin
    chain_d = out_d;
  end

  // chain feed register; driven whatever the channel mapping says
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chain_q <= `LCH_OUT_RST;
    end else begin
      chain_q <= chain_d;
    end
  end

  // channel registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      do_q <= `LCH_BANK_RST;
      ded_q <= `LCH_BANK_RST;
    end else begin
      do_q <= do_d;
      ded_q <= ded_d;
    end
  end

  // every port comes straight from a flop
  assign do_ch = do_q;
  assign chain_out = chain_q;
  assign latch_out = out_q;
  assign enabled = en_q;
  assign latched = latched_q;
  assign capture_pulse = cap_q;
  assign dedicated = ded_q;
  assign host_readback = rb_q;

endmodule : lch_latch_top

//--- sim/lch_latch_assertions.sv
`timescale 1ns/1ps
module lch_latch_assertions import lch_pkg::*; (
  // watched ports
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lch_cfg_s cfg,
  input wire lch_bank_t host_bits,
  input wire lch_bank_t do_ch,
  input wire logic chain_out,
  input wire logic latch_out,
  input wire logic enabled,
  input wire logic capture_pulse,
  input wire lch_bank_t dedicated,
  input wire lch_bank_t host_readback
);
  logic ok;
  logic trig;
  logic lvl;
  logic opx;
  // only host-sourced always-on setups are modelled, others are bench-checked
  assign ok = cfg.en_mode == LCH_EN_ALWAYS_ON && cfg.trig_src.kind == LCH_SRC_HOST
    && cfg.op_src.kind == LCH_SRC_HOST;
  assign trig = host_bits[cfg.trig_src.idx];
  assign lvl = trig == (cfg.pol == LCH_POL_HIGH);
  assign opx = host_bits[cfg.op_src.idx] ^ cfg.invert;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  follow_low_a: assert property (ok && !lvl && cfg.pol == LCH_POL_LOW
    |=> latch_out == $past(opx)) else $error("low follow wrong");
  follow_high_a: assert property (ok && !lvl && cfg.pol == LCH_POL_HIGH
    |=> latch_out == $past(opx)) else $error("high follow wrong");
  // edge into the latching level, cfg unchanged so the edge is real
  capture_edge_a: assert property (ok && lvl && !$stable(trig) && $stable(cfg)
    && $past(rst_n) |=> latch_out == $past(opx) && capture_pulse)
    else $error("capture wrong");
  hold_value_a: assert property (ok && lvl && $stable(trig) && $stable(cfg)
    && $past(rst_n) |=> $stable(latch_out)) else $error("hold lost");
  frozen_out_a: assert property (cfg.en_mode == LCH_EN_ALWAYS_OFF
    |=> $stable(latch_out) && !enabled) else $error("not frozen");
  mapped_ch_a: assert property (cfg.dest.mapped |=> dedicated == 4'h1 << $past(cfg.dest.ch)
    && do_ch[$past(cfg.dest.ch)] == latch_out) else $error("mapped channel wrong");
  unmapped_ch_a: assert property (!cfg.dest.mapped |=> do_ch == $past(host_bits))
    else $error("unmapped channel wrong");
  host_read_a: assert property (1'b1 |=> host_readback == $past(host_bits))
    else $error("readback wrong");
  chain_copy_a: assert property (chain_out == latch_out) else $error("chain differs");
  cover property (capture_pulse);
  cover property (!enabled ##1 enabled);
  cover property (ok && cfg.dest.mapped);
endmodule : lch_latch_assertions
bind lch_latch_top lch_latch_assertions i_lch_latch_assertions (.core_clk(core_clk),
  .rst_n(rst_n), .cfg(cfg), .host_bits(host_bits), .do_ch(do_ch), .chain_out(chain_out),
  .latch_out(latch_out), .enabled(enabled), .capture_pulse(capture_pulse),
  .dedicated(dedicated), .host_readback(host_readback));

//--- sim/lch_far_model.sv
`timescale 1ns/1ps
module lch_far_model import lch_pkg::*; (
  // banks the block reads
  output lch_bank_t island_in,
  output lch_bank_t virt_bits,
  output lch_bank_t host_bits,
  output logic chain_in
);
  // field inputs idle high, as with pulled-up contacts
  initial begin
    island_in = 4'hF;
    virt_bits = 4'h0;
    host_bits = 4'h0;
    chain_in = 1'b0;
  end
  // caller applies this just after a clock edge
  task automatic put(input lch_bank_t v, input lch_bank_t h, input logic c);
    virt_bits = v;
    host_bits = h;
    chain_in = c;
  endtask : put
  // island contacts change on their own; caller applies this just after an edge
  task automatic pin(input lch_bank_t p);
    island_in = p;
  endtask : pin
endmodule : lch_far_model

//--- sim/lch_latch_top_tb_top.sv
`timescale 1ns/1ps
module lch_latch_top_tb_top import lch_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  lch_cfg_s cfg = '0;
  lch_bank_t island_in, virt_bits, host_bits, do_ch, dedicated, host_readback;
  logic chain_in, chain_out, latch_out, enabled, latched, capture_pulse;
  int err_total = 0;
  int compares = 0;
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  lch_far_model i_lch_far_model (.island_in(island_in), .virt_bits(virt_bits),
    .host_bits(host_bits), .chain_in(chain_in));
  lch_latch_top i_lch_latch_top (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg),
    .island_in(island_in), .virt_bits(virt_bits), .host_bits(host_bits),
    .chain_in(chain_in), .do_ch(do_ch), .chain_out(chain_out), .latch_out(latch_out),
    .enabled(enabled), .latched(latched), .capture_pulse(capture_pulse),
    .dedicated(dedicated), .host_readback(host_readback));
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk4(input lch_bank_t got, input lch_bank_t exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t bank got %h exp %h", $time, got, exp);
    end
  endtask : chk4
  // drives 5 ns after the edge, returns once that edge's result has settled
  task automatic tick();
    @(posedge core_clk);
    #5;
  endtask : tick
  task automatic step(input logic en, input logic tr, input logic op);
    i_lch_far_model.put({3'b000, en}, {2'b00, op, tr}, 1'b0);
    tick();
  endtask : step
  task automatic setup(input lch_pol_e pol, input logic inv, input lch_en_mode_e em,
      input lch_src_e tk, input logic map);
    cfg.pol = pol;
    cfg.invert = inv;
    cfg.en_mode = em;
    cfg.en_src = '{LCH_SRC_VIRTUAL, 2'h0};
    cfg.trig_src = '{tk, 2'h0};
    cfg.op_src = '{LCH_SRC_HOST, 2'h1};
    cfg.dest = '{map, 2'h2};
  endtask : setup
  // follow, capture, hold, resume for one polarity and inversion
  task automatic t_pol(input lch_pol_e pol, input logic inv);
    logic tr;
    tr = (pol == LCH_POL_LOW);
    setup(pol, inv, LCH_EN_ALWAYS_ON, LCH_SRC_HOST, 1'b1);
    step(1'b1, tr, 1'b1);
    chk1(latch_out, 1'b1 ^ inv);
    chk1(do_ch[2], 1'b1 ^ inv);
    chk4(dedicated, 4'h4);
    step(1'b1, tr, 1'b0);
    chk1(latch_out, inv);
    step(1'b1, !tr, 1'b1);
    chk1(latch_out, !inv);
    chk1(capture_pulse, 1'b1);
    step(1'b1, !tr, 1'b0);
    chk1(latch_out, !inv);
    chk1(latched, 1'b1);
    chk1(capture_pulse, 1'b0);
    step(1'b1, tr, 1'b0);
    chk1(latch_out, inv);
    chk1(latched, 1'b0);
    $display("t_pol %0d %0d done", pol, inv);
  endtask : t_pol
  // freeze while off, lost edge, act on latest inputs when back on
  task automatic t_enable();
    setup(LCH_POL_LOW, 1'b0, LCH_EN_SIGNAL, LCH_SRC_HOST, 1'b1);
    step(1'b1, 1'b1, 1'b1);
    chk1(enabled, 1'b1);
    step(1'b0, 1'b1, 1'b0);
    chk1(latch_out, 1'b1);
    step(1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    chk1(enabled, 1'b0);
    step(1'b1, 1'b1, 1'b0);
    chk1(latch_out, 1'b0);
    cfg.en_mode = LCH_EN_ALWAYS_OFF;
    step(1'b1, 1'b1, 1'b1);
    chk1(latch_out, 1'b0);
    cfg.en_mode = LCH_EN_ALWAYS_ON;
    step(1'b0, 1'b1, 1'b1);
    chk1(latch_out, 1'b1);
    $display("t_enable done");
  endtask : t_enable
  // second stage triggered by a first stage, output to no channel
  task automatic t_chain();
    setup(LCH_POL_HIGH, 1'b0, LCH_EN_ALWAYS_ON, LCH_SRC_CHAIN, 1'b0);
    i_lch_far_model.put(4'h0, 4'hA, 1'b0);
    tick();
    chk1(chain_out, 1'b1);
    chk4(dedicated, 4'h0);
    chk4(do_ch, 4'hA);
    chk4(host_readback, 4'hA);
    i_lch_far_model.put(4'h0, 4'h0, 1'b1);
    tick();
    chk1(latch_out, 1'b0);
    i_lch_far_model.put(4'h0, 4'hA, 1'b1);
    tick();
    chk1(chain_out, 1'b0);
    $display("t_chain done");
  endtask : t_chain
  // island pin as trigger through the two-flop crossing, constant enable sources
  task automatic t_island();
    setup(LCH_POL_LOW, 1'b0, LCH_EN_SIGNAL, LCH_SRC_ISLAND, 1'b1);
    cfg.en_src = '{LCH_SRC_CONST1, 2'h0};
    i_lch_far_model.put(4'h0, 4'h2, 1'b0);
    tick();
    chk1(enabled, 1'b1);
    chk1(latch_out, 1'b1);
    i_lch_far_model.pin(4'hE);
    tick();
    chk1(latch_out, 1'b1);
    i_lch_far_model.put(4'h0, 4'h0, 1'b0);
    tick();
    chk1(latch_out, 1'b0);
    i_lch_far_model.put(4'h0, 4'h2, 1'b0);
    tick();
    chk1(latch_out, 1'b1);
    chk1(capture_pulse, 1'b1);
    i_lch_far_model.put(4'h0, 4'h0, 1'b0);
    tick();
    chk1(latch_out, 1'b1);
    cfg.en_src = '{LCH_SRC_CONST0, 2'h0};
    i_lch_far_model.pin(4'hF);
    tick();
    chk1(enabled, 1'b0);
    chk1(latch_out, 1'b1);
    $display("t_island done");
  endtask : t_island
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge core_clk);
    #5;
    rst_n = 1'b1;
    t_pol(LCH_POL_LOW, 1'b0);
    t_pol(LCH_POL_LOW, 1'b1);
    t_pol(LCH_POL_HIGH, 1'b0);
    t_pol(LCH_POL_HIGH, 1'b1);
    t_enable();
    t_chain();
    t_island();
    give_verdict();
  end
  // watchdog, far beyond the ~50 cycles the tests take
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : lch_latch_top_tb_top
